// [hdl/adm_pkg.sv]
// Constants and types for the page-mode DRAM module controller
package adm_pkg;
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned ADDR_W        = 10;
  localparam int unsigned DATA_W        = 32;
  localparam int unsigned LANES         = 4;
  localparam int unsigned WORD_ADDR_W   = 2 * ADDR_W;
  // Timings in their own units
  localparam int unsigned POWERUP_US    = 100;
  localparam int unsigned INIT_REFRESHES = 8;
  localparam int unsigned REFRESH_NS_X10 = 156;   // 15.6 us in units of 100 ns
  localparam int unsigned RC_NS         = 110;
  localparam int unsigned PC_NS         = 40;
  localparam int unsigned RAS_ACC_NS    = 60;
  localparam int unsigned CAS_ACC_NS    = 15;
  localparam int unsigned CPA_NS        = 35;
  localparam int unsigned AA_NS         = 30;
  localparam int unsigned RP_NS         = 40;
  localparam int unsigned RCD_NS        = 20;
  localparam int unsigned CP_NS         = 10;
  localparam int unsigned CSR_NS        = 10;
  localparam int unsigned RAH_NS        = 10;
  // Derived cycle counts; minimums round up
  function automatic int unsigned ns_up(input int unsigned ns);
    return (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  endfunction
  localparam int unsigned POWERUP_CYC  = POWERUP_US * 1000 * 1000 / CLK_PERIOD_PS;
  // Longest interval rounds down: 15.6 us = 15600 ns
  localparam int unsigned REFRESH_CYC  = REFRESH_NS_X10 * 100 * 1000 / CLK_PERIOD_PS;
  localparam int unsigned RC_CYC       = ns_up(RC_NS);
  localparam int unsigned PC_CYC       = ns_up(PC_NS);
  localparam int unsigned RP_CYC       = ns_up(RP_NS);
  localparam int unsigned RCD_CYC      = ns_up(RCD_NS);
  localparam int unsigned CP_CYC       = ns_up(CP_NS);
  localparam int unsigned CSR_CYC      = ns_up(CSR_NS);
  localparam int unsigned RAH_CYC      = ns_up(RAH_NS);
  localparam int unsigned RAS_ACC_CYC  = ns_up(RAS_ACC_NS);
  localparam int unsigned CAS_ACC_CYC  = ns_up(CAS_ACC_NS);
  localparam int unsigned CPA_CYC      = ns_up(CPA_NS);
  localparam int unsigned AA_CYC       = ns_up(AA_NS);
  localparam int unsigned RAS_LOW_CYC  = ns_up(RC_NS - RP_NS);
  localparam int unsigned CNT_W        = 16;
  localparam logic [LANES-1:0] LANES_OFF = 4'hF;
  localparam logic [LANES-1:0] LANES_ON  = 4'h0;
  typedef enum logic [1:0] {
    ADM_EV_NONE,
    ADM_EV_DONE,
    ADM_EV_RDATA
  } adm_event_e;
endpackage

// [hdl/adm_timer_if.sv]
// Interface between controller and its down-counting timer
`timescale 1ns/1ps
interface adm_timer_if;
  import adm_pkg::*;
  logic             load;
  logic [CNT_W-1:0] value;
  logic             expired;
  modport ctrl  (output load, output value, input expired);
  modport timer (input load, input value, output expired);
endinterface

// [hdl/adm_timer.sv]
// Loadable down counter that flags when its wait has elapsed
`timescale 1ns/1ps
module adm_timer
  import adm_pkg::*;
(
  input  wire logic  clk_i,    // System clock
  input  wire logic  rst_n_i,  // Async reset, active low
  adm_timer_if.timer tif       // Load and expiry
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  // Next count; a load of n expires n cycles later
  always_comb begin
    cnt_d = cnt_q;
    if (tif.load) begin
      cnt_d = tif.value;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Expiry ignores load: the load is decided from expiry, so a loop would form
  assign tif.expired = (cnt_q <= CNT_W'(1));
endmodule

// [hdl/adm_ctrl.sv]
// Page-mode DRAM module controller: init, refresh, page reads and writes
`timescale 1ns/1ps
module adm_ctrl
  import adm_pkg::*;
#(
  parameter int unsigned POWERUP_CYCLES = POWERUP_CYC,   // Power-up pause
  parameter int unsigned REFRESH_CYCLES = REFRESH_CYC    // Refresh spacing
) (
  input  wire logic                        clk_i,              // 200 MHz clock
  input  wire logic                        rst_n_i,            // Async reset, low
  input  wire logic                        column_first_i,     // Use internal counter refresh
  input  wire logic                        req_valid_i,        // Access request
  input  wire logic                        req_write_i,        // 1 write, 0 read
  input  wire logic [WORD_ADDR_W-1:0]      req_addr_i,         // Row high, column low
  input  wire logic [DATA_W-1:0]           req_wdata_i,        // Write data
  input  wire logic [LANES-1:0]            req_lanes_i,        // Write byte enables, high active; reads use all lanes
  input  wire logic                        req_last_i,         // Close page after this
  output logic                             req_ready_o,        // High the cycle after the request was taken
  output logic                             rdata_valid_o,      // Read data pulse
  output logic [DATA_W-1:0]                rdata_o,            // Read word
  output logic                             init_done_o,        // Init sequence complete
  output logic                             row_strobe_n_o,     // Row strobe pin
  output logic [LANES-1:0]                 column_strobe_lane_n_o, // Per-lane column strobes
  output logic [ADDR_W-1:0]                muxed_address_o,    // Row/column address pins
  output logic                             write_select_n_o,   // Write select, low writes
  output logic [DATA_W-1:0]                data_bus_o,         // Data pins, out
  output logic                             data_bus_oe_o,      // Data pins, drive enable
  input  wire logic [DATA_W-1:0]           data_bus_i          // Data pins, in
);
  typedef enum logic [3:0] {
    ST_POWERUP, ST_IDLE, ST_ROW, ST_COL, ST_COL_WAIT, ST_PRECHG_CAS,
    ST_CLOSE, ST_REF_ROW, ST_CBR_CAS, ST_CBR_RAS, ST_RP
  } adm_state_e;

  adm_timer_if tif ();
  adm_timer u_timer (.clk_i(clk_i), .rst_n_i(rst_n_i), .tif(tif));

  adm_state_e             st_q, st_d;
  logic [CNT_W-1:0]       ref_cnt_q, ref_cnt_d;
  logic                   ref_pend_q, ref_pend_d;
  logic [3:0]             init_cnt_q, init_cnt_d;
  logic                   init_q, init_d;
  logic [ADDR_W-1:0]      ref_row_q, ref_row_d;
  logic [CNT_W-1:0]       ras_cnt_q, ras_cnt_d;
  logic [CNT_W-1:0]       pc_cnt_q, pc_cnt_d;
  logic                   wr_q, wr_d, last_q, last_d, first_q, first_d;
  logic [ADDR_W-1:0]      row_q, row_d;
  logic                   ras_q, ras_d, we_q, we_d, oe_q, oe_d, rdv_q, rdv_d, rdy_q, rdy_d;
  logic [LANES-1:0]       cas_q, cas_d;
  logic [ADDR_W-1:0]      addr_q, addr_d;
  logic [DATA_W-1:0]      dout_q, dout_d, rdata_q, rdata_d;
  logic [DATA_W-1:0]      din_s1_q, din_s2_q;
  logic                   take;
  logic                   pu_armed_q;
  logic                   pu_load;

  // Two flops on returning data: pin input from outside the clock domain
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      din_s1_q <= '0;
      din_s2_q <= '0;
    end else begin
      din_s1_q <= data_bus_i;
      din_s2_q <= din_s1_q;
    end
  end

  // Read waits the latest access limit, two sync stages and one edge of margin;
  // without the margin the pin is sampled on the very edge the data turns valid
  localparam int unsigned ACC_CYC = (CAS_ACC_CYC > AA_CYC ? CAS_ACC_CYC : AA_CYC) + 3;
  localparam int unsigned CAS_LOW_CYC = (ACC_CYC > PC_CYC - CP_CYC) ? ACC_CYC : PC_CYC - CP_CYC;
  assign take = (st_q == ST_ROW || st_q == ST_COL_WAIT) && tif.expired;

  // Sequencer: next state, pins and counters
  always_comb begin
    st_d = st_q;       ref_cnt_d = ref_cnt_q; ref_pend_d = ref_pend_q;
    init_cnt_d = init_cnt_q; init_d = init_q; ref_row_d = ref_row_q;
    ras_cnt_d = (ras_cnt_q != '0) ? ras_cnt_q - 1'b1 : ras_cnt_q;
    pc_cnt_d = (pc_cnt_q != '0) ? pc_cnt_q - 1'b1 : pc_cnt_q;
    wr_d = wr_q; last_d = last_q; first_d = first_q; row_d = row_q;
    ras_d = ras_q; cas_d = cas_q; we_d = we_q; addr_d = addr_q;
    oe_d = oe_q; dout_d = dout_q; rdata_d = rdata_q; rdv_d = 1'b0; rdy_d = 1'b0;
    tif.load = 1'b0; tif.value = '0;
    // Refresh pacing; pending flag set wins over its clear
    if (ref_cnt_q >= CNT_W'(REFRESH_CYCLES - 1)) begin
      ref_cnt_d = '0;
    end else begin
      ref_cnt_d = ref_cnt_q + 1'b1;
    end
    unique case (st_q)
      ST_POWERUP: begin
        if (pu_load) begin
          tif.load = 1'b1;
          tif.value = CNT_W'(POWERUP_CYCLES);
        end else if (tif.expired) begin
          st_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        ras_d = 1'b1; cas_d = LANES_OFF; we_d = 1'b1; oe_d = 1'b0;
        if (ref_pend_q || !init_q) begin
          ref_pend_d = 1'b0;
          if (column_first_i) begin
            cas_d = LANES_ON;
            st_d = ST_CBR_CAS;
            tif.load = 1'b1; tif.value = CNT_W'(CSR_CYC);
          end else begin
            addr_d = ref_row_q;
            ras_d = 1'b0;
            st_d = ST_REF_ROW;
            tif.load = 1'b1; tif.value = CNT_W'(RAS_LOW_CYC);
            ras_cnt_d = CNT_W'(RC_CYC);
          end
        end else if (req_valid_i) begin
          row_d = req_addr_i[WORD_ADDR_W-1:ADDR_W];
          addr_d = req_addr_i[WORD_ADDR_W-1:ADDR_W];
          ras_d = 1'b0;
          ras_cnt_d = CNT_W'(RC_CYC);
          first_d = 1'b1;
          st_d = ST_ROW;
          tif.load = 1'b1; tif.value = CNT_W'(RCD_CYC > RAH_CYC ? RCD_CYC : RAH_CYC);
        end
      end
      ST_ROW, ST_COL_WAIT: begin
        if (take) begin
          if (st_q == ST_COL_WAIT && (!req_valid_i || pc_cnt_q != '0 ||
              req_addr_i[WORD_ADDR_W-1:ADDR_W] != row_q || ref_pend_q)) begin
            if (!req_valid_i || req_addr_i[WORD_ADDR_W-1:ADDR_W] != row_q || ref_pend_q) begin
              st_d = ST_CLOSE;
            end
          end else if (req_valid_i && req_addr_i[WORD_ADDR_W-1:ADDR_W] == row_q) begin
            rdy_d = 1'b1;
            addr_d = req_addr_i[ADDR_W-1:0];
            wr_d = req_write_i; last_d = req_last_i;
            we_d = !req_write_i;
            dout_d = req_wdata_i; oe_d = req_write_i;
            cas_d = req_write_i ? ~req_lanes_i : LANES_ON;
            pc_cnt_d = CNT_W'(PC_CYC);
            st_d = ST_COL;
            tif.load = 1'b1;
            // First column of a row also waits row access time, counted from row fall
            tif.value = CNT_W'(first_q ? (RAS_ACC_CYC + 3 > CAS_LOW_CYC + RCD_CYC ?
                        RAS_ACC_CYC - RCD_CYC + 3 : CAS_LOW_CYC) : CAS_LOW_CYC);
          end else if (st_q == ST_ROW) begin
            st_d = ST_CLOSE;
          end
        end
      end
      ST_COL: begin
        if (tif.expired) begin
          if (!wr_q) begin
            rdata_d = din_s2_q; rdv_d = 1'b1;
          end
          cas_d = LANES_OFF;
          oe_d = 1'b0; first_d = 1'b0;
          st_d = ST_PRECHG_CAS;
          tif.load = 1'b1; tif.value = CNT_W'(CP_CYC);
        end
      end
      ST_PRECHG_CAS: begin
        we_d = 1'b1;
        if (tif.expired) begin
          st_d = last_q ? ST_CLOSE : ST_COL_WAIT;
        end
      end
      ST_CLOSE: begin
        if (ras_cnt_q <= CNT_W'(RP_CYC)) begin
          ras_d = 1'b1;
          st_d = ST_RP;
          tif.load = 1'b1; tif.value = CNT_W'(RP_CYC);
        end
      end
      ST_REF_ROW: begin
        if (tif.expired) begin
          ras_d = 1'b1;
          ref_row_d = ref_row_q + 1'b1;
          st_d = ST_RP;
          tif.load = 1'b1; tif.value = CNT_W'(RP_CYC);
        end
      end
      ST_CBR_CAS: begin
        if (tif.expired) begin
          ras_d = 1'b0;
          st_d = ST_CBR_RAS;
          tif.load = 1'b1; tif.value = CNT_W'(RAS_LOW_CYC);
        end
      end
      ST_CBR_RAS: begin
        if (tif.expired) begin
          ras_d = 1'b1; cas_d = LANES_OFF;
          st_d = ST_RP;
          tif.load = 1'b1; tif.value = CNT_W'(RP_CYC);
        end
      end
      ST_RP: begin
        if (tif.expired) begin
          if (!init_q) begin
            init_cnt_d = init_cnt_q + 1'b1;
            init_d = (init_cnt_q == 4'(INIT_REFRESHES - 1));
          end
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
    if (ref_cnt_q >= CNT_W'(REFRESH_CYCLES - 1)) begin
      ref_pend_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= ST_POWERUP; ref_cnt_q <= '0; ref_pend_q <= 1'b0;
      init_cnt_q <= '0; init_q <= 1'b0; ref_row_q <= '0;
      ras_cnt_q <= '0; pc_cnt_q <= '0; wr_q <= 1'b0; last_q <= 1'b0; first_q <= 1'b0;
      row_q <= '0; ras_q <= 1'b1; cas_q <= LANES_OFF; we_q <= 1'b1; addr_q <= '0;
      oe_q <= 1'b0; dout_q <= '0; rdata_q <= '0; rdv_q <= 1'b0; rdy_q <= 1'b0;
    end else begin
      st_q <= st_d; ref_cnt_q <= ref_cnt_d; ref_pend_q <= ref_pend_d;
      init_cnt_q <= init_cnt_d; init_q <= init_d; ref_row_q <= ref_row_d;
      ras_cnt_q <= ras_cnt_d; pc_cnt_q <= pc_cnt_d; wr_q <= wr_d; last_q <= last_d;
      first_q <= first_d; row_q <= row_d; ras_q <= ras_d; cas_q <= cas_d; we_q <= we_d;
      addr_q <= addr_d; oe_q <= oe_d; dout_q <= dout_d; rdata_q <= rdata_d;
      rdv_q <= rdv_d; rdy_q <= rdy_d;
    end
  end

  // Power-up pause armed once after reset release
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pu_armed_q <= 1'b0;
    end else begin
      pu_armed_q <= 1'b1;
    end
  end
  assign pu_load = !pu_armed_q;

  // Pin and user outputs, all from flops
  assign row_strobe_n_o         = ras_q;
  assign column_strobe_lane_n_o = cas_q;
  assign muxed_address_o        = addr_q;
  assign write_select_n_o       = we_q;
  assign data_bus_o             = dout_q;
  assign data_bus_oe_o          = oe_q;
  assign rdata_o                = rdata_q;
  assign rdata_valid_o          = rdv_q;
  assign req_ready_o            = rdy_q;
  assign init_done_o            = init_q;
endmodule

// [testbench/adm_ctrl_chk.sv]
// Pin-level protocol checker for the page-mode DRAM controller
`timescale 1ns/1ps
module adm_ctrl_chk
  import adm_pkg::*;
#(
  parameter int unsigned POWERUP_CYCLES = 50,  // Power-up pause
  parameter int unsigned REFRESH_CYCLES = 200  // Refresh spacing
) (
  input wire logic             clk_i,                  // Clock
  input wire logic             rst_n_i,                // Async reset, low
  input wire logic             column_first_i,         // Refresh mode
  input wire logic             req_ready_o,            // Request taken
  input wire logic             init_done_o,            // Init complete
  input wire logic             row_strobe_n_o,         // Row strobe
  input wire logic [LANES-1:0] column_strobe_lane_n_o, // Column strobes
  input wire logic             write_select_n_o,       // Write select
  input wire logic             data_bus_oe_o           // Data drive enable
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Room for an open page to close before a due refresh
  localparam int unsigned GAP_SLACK = 64;
  logic        row_q;
  logic        cas_hi_q;
  logic [7:0]  rc_cnt;
  logic [7:0]  pc_cnt;
  logic [15:0] up_cnt;
  logic [15:0] gap_cnt;
  logic [3:0]  fall_cnt;
  wire         cas_low  = (column_strobe_lane_n_o != LANES_OFF);
  wire         row_fall = row_q & ~row_strobe_n_o;
  wire         cas_fall = cas_hi_q & cas_low;
  // Saturating counters since strobe falls and since reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      row_q    <= 1'b1;
      cas_hi_q <= 1'b1;
      rc_cnt   <= 8'hFF;
      pc_cnt   <= 8'hFF;
      up_cnt   <= 16'h0000;
      gap_cnt  <= 16'h0000;
      fall_cnt <= 4'h0;
    end else begin
      row_q    <= row_strobe_n_o;
      cas_hi_q <= ~cas_low;
      rc_cnt   <= row_fall ? 8'h01 : rc_cnt + {7'h00, rc_cnt != 8'hFF};
      pc_cnt   <= cas_fall ? 8'h01 : pc_cnt + {7'h00, pc_cnt != 8'hFF};
      up_cnt   <= up_cnt + {15'h0000, up_cnt != 16'hFFFF};
      gap_cnt  <= row_fall ? 16'h0001 : gap_cnt + {15'h0000, gap_cnt != 16'hFFFF};
      fall_cnt <= fall_cnt + {3'h0, row_fall && fall_cnt != 4'hF};
    end
  end
  a_init_quiet: assert property (!init_done_o |-> !req_ready_o)
    else $error("request accepted before init finished");
  a_power_pause: assert property (row_fall |-> up_cnt >= POWERUP_CYCLES)
    else $error("row strobe before power-up pause ended");
  a_init_count: assert property ($rose(init_done_o) |-> fall_cnt >= INIT_REFRESHES)
    else $error("init done after too few refreshes");
  a_init_mode: assert property (row_fall && !init_done_o |-> cas_low == column_first_i)
    else $error("init refresh of wrong kind");
  a_cbr_setup: assert property (row_fall && cas_low |-> $past(cas_low, 2))
    else $error("column strobe set up too late before row strobe");
  a_rc_space: assert property (row_fall |-> rc_cnt >= RC_CYC)
    else $error("row strobe cycle too short");
  a_page_space: assert property (cas_fall && !row_strobe_n_o |-> pc_cnt >= PC_CYC)
    else $error("page column cycle too short");
  a_refresh_gap: assert property (init_done_o |-> gap_cnt <= REFRESH_CYCLES + GAP_SLACK)
    else $error("refresh overdue");
  a_read_hold: assert property (cas_low && $past(cas_low) |-> $stable(write_select_n_o))
    else $error("write select moved while column strobe low");
  a_write_drive: assert property (cas_low && !write_select_n_o |-> data_bus_oe_o)
    else $error("write without driven data");
  a_read_float: assert property (cas_low && write_select_n_o |-> !data_bus_oe_o)
    else $error("controller drives bus during read");
endmodule
bind adm_ctrl adm_ctrl_chk #(.POWERUP_CYCLES(POWERUP_CYCLES), .REFRESH_CYCLES(REFRESH_CYCLES))
  u_adm_ctrl_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .column_first_i(column_first_i),
  .req_ready_o(req_ready_o), .init_done_o(init_done_o), .row_strobe_n_o(row_strobe_n_o),
  .column_strobe_lane_n_o(column_strobe_lane_n_o), .write_select_n_o(write_select_n_o),
  .data_bus_oe_o(data_bus_oe_o));

// [testbench/adm_dram_model.sv]
// Behavioural model of the 1M x 32 page-mode DRAM module
`timescale 1ns/1ps
module adm_dram_model
  import adm_pkg::*;
(
  input  wire logic              row_strobe_n_i,         // Row strobe
  input  wire logic [LANES-1:0]  column_strobe_lane_n_i, // Column strobes
  input  wire logic [ADDR_W-1:0] muxed_address_i,        // Muxed address
  input  wire logic              write_select_n_i,       // Write select
  input  wire logic [DATA_W-1:0] data_i,                 // Controller data
  output logic      [DATA_W-1:0] data_o,                 // Module data
  output logic      [15:0]       row_only_cnt_o,         // Row-only refreshes
  output logic      [15:0]       col_first_cnt_o         // Column-first refreshes
);
  logic [DATA_W-1:0] mem [logic [WORD_ADDR_W-1:0]];
  logic [ADDR_W-1:0] row_q;
  logic [DATA_W-1:0] w;
  logic [7:0]        tok = 8'h00;
  logic              used_q = 1'b1;
  realtime           t_row = 0.0;
  realtime           t_up = 0.0;
  realtime           d;
  wire               cas_hi = &column_strobe_lane_n_i;
  initial begin
    data_o = 32'h0000_0000;
    row_only_cnt_o = 16'h0000;
    col_first_cnt_o = 16'h0000;
  end
  // Row fall latches the row, or counts a counter-driven refresh
  always @(negedge row_strobe_n_i) begin
    t_row = $realtime;
    #1;
    used_q = ~cas_hi;
    if (!cas_hi) col_first_cnt_o++;
    else row_q = muxed_address_i;
  end
  // Row rise with no column cycle closes a row-only refresh
  always @(posedge row_strobe_n_i) if (!used_q) row_only_cnt_o++;
  // Column fall: write enabled lanes, or schedule read data
  always @(negedge cas_hi) if (!row_strobe_n_i) begin
    #1;
    used_q = 1'b1;
    w = mem.exists({row_q, muxed_address_i}) ? mem[{row_q, muxed_address_i}] : 32'h0000_0000;
    if (!write_select_n_i) begin
      for (int i = 0; i < LANES; i++) if (!column_strobe_lane_n_i[i]) w[8*i +: 8] = data_i[8*i +: 8];
      mem[{row_q, muxed_address_i}] = w;
    end else begin
      data_o = ~data_o;
      tok++;
      // Valid only after the latest access limit, never earlier
      d = 29.0;
      if (t_row + 60.0 - $realtime > d) d = t_row + 60.0 - $realtime;
      if (t_up + 35.0 - $realtime > d) d = t_up + 35.0 - $realtime;
      fork
        begin
          automatic logic [7:0] k = tok;
          #(d);
          if (k == tok && !cas_hi) data_o = w;
        end
      join_none
    end
  end
  // Released bus shows the inverse of the last value
  always @(posedge cas_hi) begin
    t_up = $realtime;
    tok++;
    data_o = ~data_o;
  end
endmodule

// [testbench/adm_ctrl_tb.sv]
// Self-checking bench for the page-mode DRAM controller
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module adm_ctrl_tb;
  import adm_pkg::*;
  // Shortened pause and refresh spacing keep the run brief
  localparam int unsigned PU = 50;
  localparam int unsigned RF = 200;
  logic                   clk_i = 1'b0;
  logic                   rst_n_i = 1'b0;
  logic                   column_first_i = 1'b0;
  logic                   req_valid_i = 1'b0;
  logic                   req_write_i = 1'b0;
  logic [WORD_ADDR_W-1:0] req_addr_i = 20'h00000;
  logic [DATA_W-1:0]      req_wdata_i = 32'h0000_0000;
  logic [LANES-1:0]       req_lanes_i = 4'h0;
  logic                   req_last_i = 1'b0;
  logic                   req_ready_o, rdata_valid_o, init_done_o, row_strobe_n_o;
  logic                   write_select_n_o, data_bus_oe_o;
  logic [DATA_W-1:0]      rdata_o, data_bus_o, mdl_dq, rd;
  logic [LANES-1:0]       column_strobe_lane_n_o;
  logic [ADDR_W-1:0]      muxed_address_o;
  logic [15:0]            ro_cnt, cf_cnt, r0, c0;
  int                     num_errors = 0;
  int                     cmp_count = 0;
  wire  [DATA_W-1:0]      data_bus_i = data_bus_oe_o ? data_bus_o : mdl_dq;
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  adm_ctrl #(.POWERUP_CYCLES(PU), .REFRESH_CYCLES(RF)) u_adm_ctrl (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .column_first_i(column_first_i), .req_valid_i(req_valid_i),
    .req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .req_lanes_i(req_lanes_i), .req_last_i(req_last_i), .req_ready_o(req_ready_o),
    .rdata_valid_o(rdata_valid_o), .rdata_o(rdata_o), .init_done_o(init_done_o),
    .row_strobe_n_o(row_strobe_n_o), .column_strobe_lane_n_o(column_strobe_lane_n_o),
    .muxed_address_o(muxed_address_o), .write_select_n_o(write_select_n_o),
    .data_bus_o(data_bus_o), .data_bus_oe_o(data_bus_oe_o), .data_bus_i(data_bus_i));
  adm_dram_model u_adm_dram_model (.row_strobe_n_i(row_strobe_n_o),
    .column_strobe_lane_n_i(column_strobe_lane_n_o), .muxed_address_i(muxed_address_o),
    .write_select_n_i(write_select_n_o), .data_i(data_bus_o), .data_o(mdl_dq),
    .row_only_cnt_o(ro_cnt), .col_first_cnt_o(cf_cnt));
  task wrap_up;
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Reset for three cycles, then wait for init under a bound
  task do_init(input logic cf);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    column_first_i <= cf;
    repeat (3) @(posedge clk_i);
    r0 = ro_cnt;
    c0 = cf_cnt;
    rst_n_i <= 1'b1;
    for (int n = 0; n < 2000 && init_done_o !== 1'b1; n++) @(posedge clk_i);
    repeat (10) @(posedge clk_i);
    `CHK(init_done_o, 1'b1)
    `CHK(ro_cnt - r0, cf ? 16'h0000 : 16'h0008)
    `CHK(cf_cnt - c0, cf ? 16'h0008 : 16'h0000)
  endtask
  // One access; request held until ready is sampled high. A read returns on the
  // edge its data is seen, so a following request still finds the page open
  task acc(input logic wr, input logic [WORD_ADDR_W-1:0] a, input logic [DATA_W-1:0] dt,
           input logic [LANES-1:0] ln, input logic last);
    req_valid_i <= 1'b1;
    req_write_i <= wr;
    req_addr_i <= a;
    req_wdata_i <= dt;
    req_lanes_i <= ln;
    req_last_i <= last;
    @(posedge clk_i);
    for (int n = 0; n < 500 && req_ready_o !== 1'b1; n++) @(posedge clk_i);
    req_valid_i <= 1'b0;
    `CHK(req_ready_o, 1'b1)
    if (!wr) begin
      for (int n = 0; n < 500 && rdata_valid_o !== 1'b1; n++) @(posedge clk_i);
      `CHK(rdata_valid_o, 1'b1)
      rd = rdata_o;
    end else begin
      @(posedge clk_i);
    end
  endtask
  task t_single;
    acc(1'b1, 20'h556AA, 32'hA5C3_0F96, 4'hF, 1'b1);
    acc(1'b0, 20'h556AA, 32'h0000_0000, 4'hF, 1'b1);
    `CHK(rd, 32'hA5C3_0F96)
  endtask
  task t_lanes;
    acc(1'b1, 20'h0C033, 32'h1122_3344, 4'hF, 1'b1);
    acc(1'b1, 20'h0C033, 32'hAABB_CCDD, 4'h5, 1'b1);
    acc(1'b0, 20'h0C033, 32'h0000_0000, 4'hF, 1'b1);
    `CHK(rd, 32'h11BB_33DD)
  endtask
  // Top row, last columns, back to back in one page
  task t_page;
    for (int i = 0; i < 4; i++) acc(1'b1, 20'(20'hFFFFC + i), 32'(32'hC0DE_0000 + i), 4'hF, i == 3);
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, 20'(20'hFFFFC + i), 32'h0000_0000, 4'hF, i == 3);
      `CHK(rd, 32'(32'hC0DE_0000 + i))
    end
  endtask
  task t_refresh;
    r0 = ro_cnt;
    repeat (5 * RF) @(posedge clk_i);
    `CHK((ro_cnt - r0 >= 16'h0004) && (ro_cnt - r0 <= 16'h0006), 1'b1)
  endtask
  // Column-first init, then stored data must survive
  task t_cbr;
    do_init(1'b1);
    acc(1'b0, 20'h556AA, 32'h0000_0000, 4'hF, 1'b1);
    `CHK(rd, 32'hA5C3_0F96)
  endtask
  initial begin
    do_init(1'b0);
    t_single;
    t_lanes;
    t_page;
    t_refresh;
    t_cbr;
    wrap_up;
  end
  // Watchdog well beyond the expected run length
  initial begin
    #100000;
    num_errors++;
    wrap_up;
  end
endmodule
